// ---- hdl/out_queue_pkg.sv ----
// Package: shared types and constants for the OUT data receive queue
package out_queue_pkg;

    localparam int EP_COUNT = 16;
    localparam int EP_W = 4;
    localparam int DATA_W = 32;
    localparam int DEPTH = 8;
    localparam int PTR_W = 3;
    localparam logic [PTR_W:0] DEPTH_CNT = 4'h8;
    localparam logic [PTR_W:0] CNT_ONE = 4'h1;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam int IRQ_W = 8;
    localparam int IRQ_MISSING_DESC = 6;
    localparam logic [EP_COUNT-1:0] EP_NONE = 16'h0000;

    typedef struct packed {
        logic [EP_W-1:0] ep;
        logic [DATA_W-1:0] data;
        logic last;
    } q_entry_t;

    typedef struct packed {
        q_entry_t [DEPTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
    } fifo_state_t;

    typedef struct packed {
        logic [EP_COUNT-1:0] missing_descriptor_error_flag;
        logic irq;
        logic head_blocked;
    } drain_state_t;

endpackage

// ---- hdl/out_queue_fifo.sv ----
// Shared in-order receive queue storage
`timescale 1ns/1ps
module out_queue_fifo
    import out_queue_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic push_i,
    input wire q_entry_t push_data_i,
    output logic full_o,
    input wire logic pop_i,
    output logic empty_o,
    output q_entry_t head_o
);

    fifo_state_t st_r;
    fifo_state_t st_nxt;
    logic do_push;
    logic do_pop;

    assign full_o = (st_r.count == DEPTH_CNT);
    assign empty_o = (st_r.count == '0);
    assign head_o = st_r.mem[st_r.rd_ptr];
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;

    always_comb
    begin
        st_nxt = st_r;
        if (do_push)
        begin
            st_nxt.mem[st_r.wr_ptr] = push_data_i;
            st_nxt.wr_ptr = st_r.wr_ptr + PTR_ONE;
        end
        if (do_pop)
        begin
            st_nxt.rd_ptr = st_r.rd_ptr + PTR_ONE;
        end
        if (do_push && !do_pop)
        begin
            st_nxt.count = st_r.count + CNT_ONE;
        end
        else if (do_pop && !do_push)
        begin
            st_nxt.count = st_r.count - CNT_ONE;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    a_count_push: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (push_i && !full_o && !pop_i) |=> (st_r.count == $past(st_r.count) + CNT_ONE))
        else $error("queue count did not rise on push");
    a_fifo_order: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (pop_i && !empty_o) |=> (st_r.rd_ptr == $past(st_r.rd_ptr) + PTR_ONE))
        else $error("read pointer did not step on pop");

endmodule // out_queue_fifo

// ---- hdl/out_queue_drain.sv ----
// OUT data receive queue with in-order drain to memory
`timescale 1ns/1ps
module usb_out_data_queue_drain
    import out_queue_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic rx_valid_i,
    input wire q_entry_t rx_entry_i,
    output logic rx_ready_o,
    input wire logic [EP_COUNT-1:0] desc_avail_i,
    input wire logic [EP_COUNT-1:0] flag_clear_i,
    output logic mem_valid_o,
    output q_entry_t mem_entry_o,
    input wire logic mem_ready_i,
    output logic desc_consume_o,
    output logic [EP_W-1:0] desc_consume_ep_o,
    output logic [EP_COUNT-1:0] endpoint_status_register_o,
    output logic [IRQ_W-1:0] irq_o,
    output logic head_blocked_o
);

    drain_state_t st_r;
    drain_state_t st_nxt;
    logic fifo_full;
    logic fifo_empty;
    q_entry_t head;
    logic rx_take;
    logic head_has_desc;
    logic pop;
    logic [EP_COUNT-1:0] set_vec;

    out_queue_fifo u_fifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .push_i(rx_take),
        .push_data_i(rx_entry_i),
        .full_o(fifo_full),
        .pop_i(pop),
        .empty_o(fifo_empty),
        .head_o(head)
    );

    assign rx_ready_o = !fifo_full;
    assign rx_take = rx_valid_i && !fifo_full;
    // Only the head is ever considered; later ready endpoints wait
    assign head_has_desc = desc_avail_i[head.ep];
    assign mem_valid_o = !fifo_empty && head_has_desc;
    assign mem_entry_o = head;
    assign pop = mem_valid_o && mem_ready_i;
    // Descriptor is used up at the packet's last word
    assign desc_consume_o = pop && head.last;
    assign desc_consume_ep_o = head.ep;
    assign endpoint_status_register_o = st_r.missing_descriptor_error_flag;
    assign head_blocked_o = st_r.head_blocked;

    genvar g;
    generate
        for (g = 0; g < EP_COUNT; g++)
        begin : g_set
            assign set_vec[g] = rx_take && (rx_entry_i.ep == EP_W'(g)) && !desc_avail_i[g];

            a_flag_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
                (endpoint_status_register_o[g] && !flag_clear_i[g])
                |=> endpoint_status_register_o[g])
                else $error("missing descriptor flag dropped");

            a_flag_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
                (flag_clear_i[g] && !set_vec[g])
                |=> !endpoint_status_register_o[g])
                else $error("missing descriptor flag not cleared");

            a_flag_cause: assert property (@(posedge clock_i) disable iff (!resetn_i)
                $rose(endpoint_status_register_o[g])
                |-> $past(set_vec[g]))
                else $error("flag set without a cause");
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        // Set beats clear so a fresh event is never lost
        st_nxt.missing_descriptor_error_flag =
            (st_r.missing_descriptor_error_flag & ~flag_clear_i) | set_vec;
        st_nxt.irq = |st_nxt.missing_descriptor_error_flag;
        st_nxt.head_blocked = !fifo_empty && !head_has_desc;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    always_comb
    begin
        irq_o = '0;
        irq_o[IRQ_MISSING_DESC] = st_r.irq;
    end

    // Head gating: a missing descriptor at the head stalls the drain for every endpoint
    a_head_gate: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (!fifo_empty && desc_avail_i[head.ep])
        |-> mem_valid_o)
        else $error("head with descriptor not offered");

    a_head_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !desc_avail_i[mem_entry_o.ep]
        |-> !mem_valid_o)
        else $error("head released without descriptor");

    a_head_stall: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (!fifo_empty && !desc_avail_i[head.ep])
        |=> (head == $past(head)) && head_blocked_o)
        else $error("blocked head moved or not reported");

    a_unblocked: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (fifo_empty || desc_avail_i[head.ep])
        |=> !head_blocked_o)
        else $error("blocked reported without a stall");

    a_stall_all: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (!fifo_empty && !desc_avail_i[head.ep])
        |-> (!mem_valid_o && !desc_consume_o))
        else $error("later entry passed a blocked head");

    a_stuck_full: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (fifo_full && !desc_avail_i[head.ep])
        |=> !rx_ready_o)
        else $error("locked queue accepted data");

    a_empty_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
        fifo_empty
        |-> (!mem_valid_o && !desc_consume_o))
        else $error("empty queue offered data");

    a_head_steady: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (mem_valid_o && !mem_ready_i)
        |=> (mem_entry_o == $past(mem_entry_o)))
        else $error("waiting head changed");

    a_accept_entry: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (rx_valid_i && rx_ready_o && fifo_empty)
        |=> (mem_entry_o == $past(rx_entry_i)))
        else $error("first word not at head");

    a_consume_last: assert property (@(posedge clock_i) disable iff (!resetn_i)
        desc_consume_o
        |-> (mem_valid_o && mem_ready_i && mem_entry_o.last))
        else $error("descriptor used up off a packet end");

    a_consume_ep: assert property (@(posedge clock_i) disable iff (!resetn_i)
        desc_consume_o
        |-> (desc_consume_ep_o == mem_entry_o.ep))
        else $error("descriptor used up for wrong endpoint");

    // Missing-descriptor reporting
    a_irq_raise: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (rx_valid_i && rx_ready_o && !desc_avail_i[rx_entry_i.ep])
        |=> irq_o[IRQ_MISSING_DESC])
        else $error("missing descriptor interrupt not raised");

    a_irq_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (endpoint_status_register_o == EP_NONE)
        |-> !irq_o[IRQ_MISSING_DESC])
        else $error("interrupt without flag");

    a_irq_level: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (|endpoint_status_register_o)
        |-> irq_o[IRQ_MISSING_DESC])
        else $error("flag pending without interrupt");

    a_irq_spare: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (irq_o[IRQ_W-1:IRQ_MISSING_DESC+1] == '0)
        && (irq_o[IRQ_MISSING_DESC-1:0] == '0))
        else $error("unused interrupt line driven");

    a_flag_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (rx_valid_i && rx_ready_o && !desc_avail_i[rx_entry_i.ep])
        |=> endpoint_status_register_o[$past(rx_entry_i.ep)])
        else $error("missing descriptor flag not set");

    a_set_wins: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (rx_valid_i && rx_ready_o && !desc_avail_i[rx_entry_i.ep] && flag_clear_i[rx_entry_i.ep])
        |=> endpoint_status_register_o[$past(rx_entry_i.ep)])
        else $error("clear beat a fresh missing descriptor event");

    // Receive side back-pressure
    a_ready_full: assert property (@(posedge clock_i) disable iff (!resetn_i)
        fifo_full
        |-> !rx_ready_o)
        else $error("accepting while full");

    a_ready_room: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !fifo_full
        |-> rx_ready_o)
        else $error("refusing while room is left");

    a_full_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (fifo_full && !mem_ready_i)
        |=> fifo_full)
        else $error("full queue lost an entry");

    c_drain: cover property (@(posedge clock_i) disable iff (!resetn_i) pop);
    c_block: cover property (@(posedge clock_i) disable iff (!resetn_i) head_blocked_o ##3 pop);
    c_full: cover property (@(posedge clock_i) disable iff (!resetn_i) fifo_full);
    c_set_clear: cover property (@(posedge clock_i) disable iff (!resetn_i) |(set_vec & flag_clear_i));
    c_packet: cover property (@(posedge clock_i) disable iff (!resetn_i) (pop && !head.last) ##1 desc_consume_o);

endmodule // usb_out_data_queue_drain

// ---- bench/usb_host_model.sv ----
// Behavioural USB host offering OUT data words to the queue
`timescale 1ns/1ps
module usb_host_model
    import out_queue_pkg::*;
(
    input wire logic clock_i,
    input wire logic ready_i,
    output logic valid_o,
    output q_entry_t entry_o
);
    initial
    begin
        valid_o = 1'b0;
        entry_o = '0;
    end
    // One idle cycle between words keeps valid from toggling twice in a step
    task automatic put(input logic [EP_W-1:0] ep, input logic [DATA_W-1:0] d, input logic lst, output bit ok);
        int n;
        ok = 1'b0;
        @(negedge clock_i);
        valid_o = 1'b1;
        entry_o = '{ep: ep, data: d, last: lst};
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge clock_i);
            ok = ready_i;
        end
        @(negedge clock_i);
        valid_o = 1'b0;
        // Released bus shows inverted data, never the stale word
        entry_o.data = ~d;
    endtask
endmodule // usb_host_model

// ---- bench/usb_out_data_queue_drain_tb.sv ----
// Self-checking bench for the OUT data queue drain
`timescale 1ns/1ps
module usb_out_data_queue_drain_tb;
    import out_queue_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
$display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
    logic clock_i, resetn_i, rx_valid_i, rx_ready_o, mem_valid_o, mem_ready_i, desc_consume_o, head_blocked_o;
    q_entry_t rx_entry_i, mem_entry_o;
    logic [EP_COUNT-1:0] desc_avail_i, flag_clear_i, endpoint_status_register_o;
    logic [EP_W-1:0] desc_consume_ep_o;
    logic [IRQ_W-1:0] irq_o;
    int err_count = 0;
    int checks_done = 0;
    bit ok;
    usb_host_model host (.clock_i(clock_i), .ready_i(rx_ready_o), .valid_o(rx_valid_i), .entry_o(rx_entry_i));
    usb_out_data_queue_drain dut (.clock_i(clock_i), .resetn_i(resetn_i), .rx_valid_i(rx_valid_i),
        .rx_entry_i(rx_entry_i), .rx_ready_o(rx_ready_o), .desc_avail_i(desc_avail_i),
        .flag_clear_i(flag_clear_i), .mem_valid_o(mem_valid_o), .mem_entry_o(mem_entry_o),
        .mem_ready_i(mem_ready_i), .desc_consume_o(desc_consume_o), .desc_consume_ep_o(desc_consume_ep_o),
        .endpoint_status_register_o(endpoint_status_register_o), .irq_o(irq_o), .head_blocked_o(head_blocked_o));
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_stall();
        desc_avail_i = 16'h0004;
        mem_ready_i = 1'b1;
        host.put(4'h1, 32'h1111_1111, 1'b1, ok);
        `CHK(ok, 1'b1);
        `CHK(endpoint_status_register_o, 16'h0002);
        `CHK(irq_o, 8'h40);
        `CHK(mem_valid_o, 1'b0);
        host.put(4'h2, 32'h2222_2222, 1'b1, ok);
        `CHK(ok, 1'b1);
        `CHK(irq_o, 8'h40);
        `CHK(mem_valid_o, 1'b0);
        `CHK(mem_entry_o.ep, 4'h1);
        `CHK(head_blocked_o, 1'b1);
        flag_clear_i = 16'h0002;
        @(negedge clock_i);
        flag_clear_i = 16'h0000;
        `CHK(endpoint_status_register_o, 16'h0000);
        desc_avail_i = 16'h0006;
        #1;
        `CHK(mem_valid_o, 1'b1);
        `CHK(mem_entry_o.data, 32'h1111_1111);
        `CHK(desc_consume_o, 1'b1);
        `CHK(desc_consume_ep_o, 4'h1);
        @(negedge clock_i);
        `CHK(mem_entry_o.data, 32'h2222_2222);
        `CHK(irq_o, 8'h00);
        @(negedge clock_i);
        `CHK(mem_valid_o, 1'b0);
        $display("t_stall done");
    endtask
    task automatic t_full();
        int i;
        mem_ready_i = 1'b0;
        desc_avail_i = 16'hFFFF;
        for (i = 0; i < 8; i++)
        begin
            host.put(EP_W'(i), DATA_W'(i), 1'b1, ok);
            `CHK(ok, 1'b1);
        end
        `CHK(rx_ready_o, 1'b0);
        host.put(4'h3, 32'h0000_0009, 1'b1, ok);
        `CHK(ok, 1'b0);
        mem_ready_i = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            `CHK(mem_entry_o.data, DATA_W'(i));
            @(negedge clock_i);
        end
        `CHK(mem_valid_o, 1'b0);
        `CHK(endpoint_status_register_o, 16'h0000);
        $display("t_full done");
    endtask
    task automatic t_packet();
        mem_ready_i = 1'b0;
        host.put(4'h3, 32'hAAAA_0001, 1'b0, ok);
        `CHK(ok, 1'b1);
        host.put(4'h3, 32'hAAAA_0002, 1'b1, ok);
        `CHK(ok, 1'b1);
        mem_ready_i = 1'b1;
        #1;
        `CHK(mem_entry_o.data, 32'hAAAA_0001);
        `CHK(desc_consume_o, 1'b0);
        @(negedge clock_i);
        `CHK(mem_entry_o.data, 32'hAAAA_0002);
        `CHK(desc_consume_o, 1'b1);
        `CHK(desc_consume_ep_o, 4'h3);
        @(negedge clock_i);
        `CHK(mem_valid_o, 1'b0);
        $display("t_packet done");
    endtask
    task automatic t_reset();
        desc_avail_i = 16'hFFDF;
        // Clear held across the take edge: the fresh event must survive
        flag_clear_i = 16'h0020;
        host.put(4'h5, 32'h5555_5555, 1'b1, ok);
        flag_clear_i = 16'h0000;
        `CHK(ok, 1'b1);
        `CHK(endpoint_status_register_o, 16'h0020);
        `CHK(irq_o, 8'h40);
        `CHK(mem_valid_o, 1'b0);
        resetn_i = 1'b0;
        #1;
        `CHK(endpoint_status_register_o, 16'h0000);
        `CHK(irq_o, 8'h00);
        `CHK(rx_ready_o, 1'b1);
        `CHK(mem_valid_o, 1'b0);
        repeat (4) @(negedge clock_i);
        resetn_i = 1'b1;
        desc_avail_i = 16'hFFFF;
        host.put(4'h7, 32'h7777_7777, 1'b1, ok);
        `CHK(ok, 1'b1);
        `CHK(head_blocked_o, 1'b0);
        `CHK(mem_entry_o.data, 32'h7777_7777);
        `CHK(mem_valid_o, 1'b1);
        @(negedge clock_i);
        `CHK(mem_valid_o, 1'b0);
        $display("t_reset done");
    endtask
    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial
    begin
        resetn_i = 1'b0;
        desc_avail_i = 16'h0000;
        flag_clear_i = 16'h0000;
        mem_ready_i = 1'b0;
        repeat (4) @(negedge clock_i);
        resetn_i = 1'b1;
        t_stall();
        t_full();
        t_packet();
        t_reset();
        wrap_up();
    end
endmodule // usb_out_data_queue_drain_tb
